// ==== fsec_pkg.sv ====
// Constants and types shared by the flash security and clock ratio block.
// Assumes a byte-wide register path on the bus clock.
package fsec_pkg;
    // ****************************************
    // Register layout
    // ****************************************
    localparam int unsigned RATIO_LOADED_BIT = 7;
    localparam int unsigned PRESCALE_BIT = 6;
    localparam int unsigned DIVISOR_MSB = 5;
    localparam int unsigned KEY_WRITE_MODE_BIT = 5;
    localparam int unsigned BACKDOOR_ALLOW_BIT = 7;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] RATIO_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] PROTECT_RESET = 8'hFF;
    localparam int unsigned KEY_BYTES = 8;
    localparam logic [2:0] KEY_LAST_INDEX = 3'h7;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [15:0] KEY_BASE_ADDR = 16'hFFB0;
    localparam int unsigned NV_BLOCK_BYTES = 512;

    // ****************************************
    // Key entry states
    // ****************************************
    typedef enum logic [1:0] {
        FSEC_KEY_IDLE = 2'b00,
        FSEC_KEY_COLLECT = 2'b01,
        FSEC_KEY_CHECK = 2'b11
    } fsec_key_state_e;
endpackage : fsec_pkg

// ==== fsec_key_if.sv ====
// Carries key-entry events from the security gate to the key comparator.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface fsec_key_if;
    logic arm;
    logic key_wr;
    logic [2:0] key_idx;
    logic [7:0] key_data;
    logic finish;
    logic match;

    modport gate (output arm, output key_wr, output key_idx, output key_data, output finish, input match);
    modport cmp (input arm, input key_wr, input key_idx, input key_data, input finish, output match);
endinterface : fsec_key_if

// ==== fsec_key_cmp.sv ====
// Collects eight key bytes in order and compares them against the stored key.
// Assumes the stored key is stable from reset onward.
`timescale 1ns/10ps
module fsec_key_cmp (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [63:0] stored_key_i,
    fsec_key_if.cmp key
);
    fsec_pkg::fsec_key_state_e state_q;
    logic [2:0] next_idx_q;
    logic all_ok_q;
    logic match_q;

    // ****************************************
    // Ordered comparison
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= fsec_pkg::FSEC_KEY_IDLE;
            next_idx_q <= 3'h0;
            all_ok_q <= 1'b0;
        end else begin
            case (state_q)
                fsec_pkg::FSEC_KEY_IDLE: begin
                    if (key.arm) begin
                        state_q <= fsec_pkg::FSEC_KEY_COLLECT;
                        next_idx_q <= 3'h0;
                        all_ok_q <= 1'b1;
                    end
                end
                fsec_pkg::FSEC_KEY_COLLECT: begin
                    if (key.finish) begin
                        state_q <= fsec_pkg::FSEC_KEY_IDLE;
                    end else if (key.key_wr) begin
                        // Out of order or wrong byte spoils the whole attempt
                        if (key.key_idx != next_idx_q ||
                            key.key_data != stored_key_i[key.key_idx*8 +: 8]) begin
                            all_ok_q <= 1'b0;
                        end
                        if (next_idx_q == fsec_pkg::KEY_LAST_INDEX) begin
                            state_q <= fsec_pkg::FSEC_KEY_CHECK;
                        end
                        next_idx_q <= next_idx_q + 3'h1;
                    end
                end
                fsec_pkg::FSEC_KEY_CHECK: begin
                    if (key.finish) begin
                        state_q <= fsec_pkg::FSEC_KEY_IDLE;
                    end else if (key.key_wr) begin
                        all_ok_q <= 1'b0;
                    end
                end
                default: state_q <= fsec_pkg::FSEC_KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= key.finish && state_q == fsec_pkg::FSEC_KEY_CHECK && all_ok_q;
        end
    end

    assign key.match = match_q;
endmodule : fsec_key_cmp

// ==== fsec_clk_div.sv ====
// Flash clock generator: optional divide by eight, then divide by divisor plus one.
// Assumes the ratio is held constant once loaded.
`timescale 1ns/10ps
module fsec_clk_div #(
    parameter int unsigned DIV_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic prescale_i,
    input wire logic [DIV_W-1:0] divisor_i,
    output logic tick_o
);
    logic [2:0] pre_q;
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;
    logic pre_tick;

    assign pre_tick = !prescale_i || pre_q == fsec_pkg::PRESCALE_LAST;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= 3'h0;
        end else if (!run_i) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // One flash clock tick every (divisor+1) prescaled ticks
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (!run_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (pre_tick) begin
            tick_q <= cnt_q == divisor_i;
            cnt_q <= (cnt_q == divisor_i) ? '0 : cnt_q + 1'b1;
        end else begin
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;
endmodule : fsec_clk_div

// ==== fsec_gate.sv ====
// Security gate for flash and RAM, backdoor unlock, blank-check unlock,
// and the write-once flash clock ratio register.
// Assumes one bus clock; nonvolatile bytes are stable inputs sampled at reset release.
// Contract
// - While secure, unsecured-code or debug accesses to flash/RAM are blocked, reads zero.
// - Security code 1:0 is unsecured; every other value is secure.
// - Reset copies the stored option byte into the working option register.
// - Debug module enable is held off while secure; register space stays reachable.
// - With backdoor allow clear, no backdoor unlock exists.
// - Key write mode turns key location writes into comparison values.
// - Leaving key write mode with a full matching key sets code to 1:0.
// - Key writes count only from secure-memory code, not debug.
// - Working protection register is writable only by debug commands.
// - A fully blank flash check disengages security until reset.
// - Backdoor key lives in the last 512-byte block with the vectors.
// - Reset also loads the working protection register from its stored copy.
// - Ratio loaded flag is read-only, reset clear, set by first write.
// - Ratio bits 6:0 are always readable, writable once after reset.
// - Program and erase are disabled until the ratio has been loaded.
// - Prescale bit selects bus clock or bus clock divided by eight.
// - Flash clock is the selected clock divided by divisor plus one.
// - Each program/erase pulse is one flash clock cycle; operations count pulses.
// - Flash writes before the ratio is loaded raise the access error flag.
`timescale 1ns/10ps
module fsec_gate (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] stored_option_byte_i,
    input wire logic [7:0] stored_protect_byte_i,
    input wire logic [63:0] backdoor_key_store_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic acc_secure_mem_i,
    input wire logic acc_debug_i,
    input wire logic acc_to_secure_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_en_o,
    output logic [7:0] acc_rdata_o,
    input wire logic ratio_wr_i,
    input wire logic [7:0] ratio_wdata_i,
    output logic [7:0] flash_clock_ratio_reg_o,
    input wire logic config_wr_i,
    input wire logic [7:0] config_wdata_i,
    output logic [7:0] flash_config_reg_o,
    input wire logic protect_wr_i,
    input wire logic [7:0] protect_wdata_i,
    output logic [7:0] working_protect_reg_o,
    output logic [7:0] working_option_reg_o,
    input wire logic blank_ok_i,
    input wire logic pulse_req_i,
    output logic pulse_o,
    output logic prog_erase_en_o,
    output logic flash_cmd_write_o,
    output logic access_error_set_o,
    output logic secure_o,
    output logic debug_module_allow_o
);
    logic [7:0] ratio_q;
    logic [7:0] config_q;
    logic [7:0] protect_q;
    logic [7:0] option_q;
    logic load_pending_q;
    logic [7:0] rdata_q;
    logic err_q;
    logic unlock_q;
    logic pulse_q;
    logic secure;
    logic allowed;
    logic key_window;
    logic flash_tick;

    fsec_key_if key ();

    // ****************************************
    // Reset loads of nonvolatile copies
    // ****************************************
    function automatic logic is_secure(input logic [1:0] code);
        is_secure = code != fsec_pkg::SEC_UNSECURED;
    endfunction : is_secure

    // Stored bytes are taken on the first edge after release, never under reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_pending_q <= 1'b1;
        end else begin
            load_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            option_q <= fsec_pkg::OPTION_RESET;
        end else if (load_pending_q) begin
            option_q <= stored_option_byte_i;
        end else if (unlock_q) begin
            option_q[1:0] <= fsec_pkg::SEC_UNSECURED;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            protect_q <= fsec_pkg::PROTECT_RESET;
        end else if (load_pending_q) begin
            protect_q <= stored_protect_byte_i;
        end else if (protect_wr_i && acc_debug_i) begin
            protect_q <= protect_wdata_i;
        end
    end

    // Held secure during the load cycle so nothing slips through before option is known
    assign secure = load_pending_q || is_secure(option_q[1:0]);
    assign allowed = !(secure && acc_to_secure_i && (acc_debug_i || !acc_secure_mem_i));

    // ****************************************
    // Access gate
    // ****************************************
    assign mem_en_o = acc_valid_i && allowed && !(key_window && acc_write_i);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (acc_valid_i && !acc_write_i) begin
            rdata_q <= allowed ? mem_rdata_i : 8'h00;
        end
    end

    assign acc_rdata_o = rdata_q;
    assign debug_module_allow_o = !secure;
    assign secure_o = secure;

    // ****************************************
    // Backdoor key entry
    // ****************************************
    // Key locations sit in the last nonvolatile block, under the vector protection
    assign key_window = config_q[fsec_pkg::KEY_WRITE_MODE_BIT] &&
                        acc_addr_i[15:3] == fsec_pkg::KEY_BASE_ADDR[15:3];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            config_q <= fsec_pkg::CONFIG_RESET;
        end else if (config_wr_i) begin
            config_q <= config_wdata_i;
        end
    end

    assign key.arm = config_wr_i && !config_q[fsec_pkg::KEY_WRITE_MODE_BIT] &&
                     config_wdata_i[fsec_pkg::KEY_WRITE_MODE_BIT] &&
                     option_q[fsec_pkg::BACKDOOR_ALLOW_BIT];
    assign key.key_wr = acc_valid_i && acc_write_i && key_window &&
                        acc_secure_mem_i && !acc_debug_i;
    assign key.key_idx = acc_addr_i[2:0];
    assign key.key_data = acc_wdata_i;
    assign key.finish = config_wr_i && config_q[fsec_pkg::KEY_WRITE_MODE_BIT] &&
                        !config_wdata_i[fsec_pkg::KEY_WRITE_MODE_BIT];

    fsec_key_cmp u_key_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .stored_key_i(backdoor_key_store_i),
        .key(key)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            unlock_q <= 1'b0;
        end else begin
            unlock_q <= (key.match && option_q[fsec_pkg::BACKDOOR_ALLOW_BIT]) || blank_ok_i;
        end
    end

    // ****************************************
    // Write-once clock ratio
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ratio_q <= fsec_pkg::RATIO_RESET;
        end else if (ratio_wr_i && !ratio_q[fsec_pkg::RATIO_LOADED_BIT]) begin
            ratio_q <= {1'b1, ratio_wdata_i[6:0]};
        end
    end

    assign flash_clock_ratio_reg_o = ratio_q;
    assign prog_erase_en_o = ratio_q[fsec_pkg::RATIO_LOADED_BIT];

    fsec_clk_div #(
        .DIV_W(fsec_pkg::DIVISOR_MSB + 1)
    ) u_clk_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(ratio_q[fsec_pkg::RATIO_LOADED_BIT]),
        .prescale_i(ratio_q[fsec_pkg::PRESCALE_BIT]),
        .divisor_i(ratio_q[fsec_pkg::DIVISOR_MSB:0]),
        .tick_o(flash_tick)
    );

    // Pulse lasts from one flash clock tick to the next; sequencer counts these
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_q <= 1'b0;
        end else if (flash_tick) begin
            pulse_q <= pulse_req_i && prog_erase_en_o;
        end
    end

    assign pulse_o = pulse_q;

    // ****************************************
    // Flash command writes and access error
    // ****************************************
    assign flash_cmd_write_o = acc_valid_i && acc_write_i && allowed && !key_window &&
                               !acc_to_secure_i && prog_erase_en_o;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            err_q <= 1'b0;
        end else begin
            err_q <= acc_valid_i && acc_write_i && !acc_to_secure_i && !key_window &&
                     !ratio_q[fsec_pkg::RATIO_LOADED_BIT];
        end
    end

    assign access_error_set_o = err_q;
    assign flash_config_reg_o = config_q;
    assign working_protect_reg_o = protect_q;
    assign working_option_reg_o = option_q;
endmodule : fsec_gate

// ==== fsec_gate_assertions.sv ====
// Port level assertions for the flash security gate.
// Assumes the gate's bus clock and its async active high reset.
`timescale 1ns/10ps
module fsec_gate_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic acc_secure_mem_i,
    input wire logic acc_debug_i,
    input wire logic acc_to_secure_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic [7:0] acc_rdata_o,
    input wire logic mem_en_o,
    input wire logic ratio_wr_i,
    input wire logic [7:0] ratio_wdata_i,
    input wire logic [7:0] flash_clock_ratio_reg_o,
    input wire logic protect_wr_i,
    input wire logic [7:0] working_protect_reg_o,
    input wire logic [7:0] working_option_reg_o,
    input wire logic blank_ok_i,
    input wire logic prog_erase_en_o,
    input wire logic access_error_set_o,
    input wire logic secure_o,
    input wire logic debug_module_allow_o
);
    // ****************
    // Checks
    // ****************
    logic blk;
    logic [6:0] wd;
    assign blk = secure_o && acc_valid_i && acc_to_secure_i && (acc_debug_i || !acc_secure_mem_i);
    assign wd = ratio_wdata_i[6:0];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_block_enable: assert property (blk |-> !mem_en_o)
        else $error("blocked access reached memory");
    a_block_rdata: assert property (blk && !acc_write_i |=> acc_rdata_o == 8'h00)
        else $error("blocked read returned data");
    a_code_state: assert property (secure_o == (working_option_reg_o[1:0] != 2'h2))
        else $error("security state disagrees with code");
    a_debug_gate: assert property (debug_module_allow_o == !secure_o)
        else $error("debug module allowed while secure");
    a_ratio_first: assert property (!flash_clock_ratio_reg_o[7] && ratio_wr_i |=>
        flash_clock_ratio_reg_o == {1'b1, $past(wd)})
        else $error("first ratio write not taken");
    a_ratio_hold: assert property (flash_clock_ratio_reg_o[7] |=> $stable(flash_clock_ratio_reg_o))
        else $error("ratio changed after load");
    a_pe_loaded: assert property (prog_erase_en_o == flash_clock_ratio_reg_o[7])
        else $error("program enable differs from loaded flag");
    a_protect_app: assert property (protect_wr_i && !acc_debug_i |=> $stable(working_protect_reg_o))
        else $error("application changed protection");
    a_blank_open: assert property (blank_ok_i |-> ##2 !secure_o)
        else $error("blank check did not unlock");
    a_early_error: assert property (acc_valid_i && acc_write_i && !acc_to_secure_i &&
        !flash_clock_ratio_reg_o[7] && acc_addr_i[15:3] != 13'h1FF6 |=> access_error_set_o)
        else $error("early flash write gave no error");
endmodule : fsec_gate_chk

bind fsec_gate fsec_gate_chk i_chk (.*);

// ==== fsec_cpu_model.sv ====
// Behavioural CPU and background debug controller on the gate's bus.
// Assumes requests launch on the falling edge of the bus clock.
`timescale 1ns/10ps
module fsec_cpu_model (
    input wire logic clk_i,
    input wire logic mem_en_i,
    input wire logic [7:0] rdata_i,
    input wire logic err_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic acc_secure_mem_o,
    output logic acc_debug_o,
    output logic acc_to_secure_o,
    output logic [15:0] acc_addr_o,
    output logic [7:0] acc_wdata_o,
    output logic [7:0] mem_rdata_o,
    output logic protect_wr_o,
    output logic [7:0] protect_wdata_o
);
    // ****************
    // Bus cycles
    // ****************
    // Memory pattern depends on the address so stale data cannot match
    assign mem_rdata_o = acc_addr_o[7:0] ^ 8'hA5;
    initial begin
        {acc_valid_o, acc_write_o, acc_secure_mem_o, acc_debug_o, acc_to_secure_o} = 5'h00;
        acc_addr_o = 16'h0000;
        acc_wdata_o = 8'h00;
        protect_wr_o = 1'b0;
        protect_wdata_o = 8'h00;
    end
    task acc(input logic w, sm, dbg, ts, input logic [15:0] a, input logic [7:0] d,
             output logic en, output logic [7:0] rd, output logic er);
        @(negedge clk_i);
        {acc_write_o, acc_secure_mem_o, acc_debug_o, acc_to_secure_o} = {w, sm, dbg, ts};
        acc_addr_o = a;
        acc_wdata_o = d;
        acc_valid_o = 1'b1;
        #1;
        en = mem_en_i;
        @(negedge clk_i);
        acc_valid_o = 1'b0;
        acc_wdata_o = ~d;
        rd = rdata_i;
        er = err_i;
        // Idle cycle keeps key writes off adjacent bus cycles
        @(negedge clk_i);
    endtask : acc
    task prot(input logic dbg, input logic [7:0] d);
        @(negedge clk_i);
        acc_debug_o = dbg;
        protect_wdata_o = d;
        protect_wr_o = 1'b1;
        @(negedge clk_i);
        protect_wr_o = 1'b0;
        protect_wdata_o = ~d;
    endtask : prot
endmodule : fsec_cpu_model

// ==== test_flash_security_and_clock_divider.sv ====
// Self-checking bench for the flash security gate.
// Assumes fsec_cpu_model stands in for the CPU and debug controller.
`timescale 1ns/10ps
module test_flash_security_and_clock_divider;
    localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] stored_option_byte_i = 8'h83;
    logic [7:0] stored_protect_byte_i = 8'hF8;
    logic [63:0] backdoor_key_store_i = KEY;
    logic ratio_wr_i = 1'b0, config_wr_i = 1'b0, blank_ok_i = 1'b0, pulse_req_i = 1'b0;
    logic [7:0] ratio_wdata_i = 8'h00, config_wdata_i = 8'h00;
    wire logic acc_valid_i, acc_write_i, acc_secure_mem_i, acc_debug_i, acc_to_secure_i, protect_wr_i;
    wire logic [15:0] acc_addr_i;
    wire logic [7:0] acc_wdata_i, mem_rdata_i, protect_wdata_i, acc_rdata_o, flash_clock_ratio_reg_o;
    wire logic [7:0] flash_config_reg_o, working_protect_reg_o, working_option_reg_o;
    wire logic mem_en_o, pulse_o, prog_erase_en_o, flash_cmd_write_o, access_error_set_o;
    wire logic secure_o, debug_module_allow_o;
    int err_count = 0, n_compared = 0, n;
    logic e, er;
    logic [7:0] rd;
    fsec_gate i_dut (.clk_i, .rst_i, .stored_option_byte_i, .stored_protect_byte_i, .backdoor_key_store_i,
        .acc_valid_i, .acc_write_i, .acc_secure_mem_i, .acc_debug_i, .acc_to_secure_i, .acc_addr_i,
        .acc_wdata_i, .mem_rdata_i, .mem_en_o, .acc_rdata_o, .ratio_wr_i, .ratio_wdata_i,
        .flash_clock_ratio_reg_o, .config_wr_i, .config_wdata_i, .flash_config_reg_o, .protect_wr_i,
        .protect_wdata_i, .working_protect_reg_o, .working_option_reg_o, .blank_ok_i, .pulse_req_i,
        .pulse_o, .prog_erase_en_o, .flash_cmd_write_o, .access_error_set_o, .secure_o, .debug_module_allow_o);
    fsec_cpu_model i_cpu (.clk_i, .mem_en_i(mem_en_o), .rdata_i(acc_rdata_o), .err_i(access_error_set_o),
        .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i), .acc_secure_mem_o(acc_secure_mem_i),
        .acc_debug_o(acc_debug_i), .acc_to_secure_o(acc_to_secure_i), .acc_addr_o(acc_addr_i),
        .acc_wdata_o(acc_wdata_i), .mem_rdata_o(mem_rdata_i), .protect_wr_o(protect_wr_i),
        .protect_wdata_o(protect_wdata_i));
    always #12.5 clk_i = ~clk_i;
    // Command-write output only stands during the access, so keep the last decision
    logic cmd_seen = 1'b0;
    always @(posedge clk_i) begin
        if (acc_valid_i) begin
            cmd_seen <= flash_cmd_write_o;
        end
    end
    // ****************
    // Helpers
    // ****************
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task guard(input int lim);
        if (n >= lim) begin
            err_count++;
            summarize();
        end
    endtask : guard
    task do_reset(input logic [7:0] o);
        stored_option_byte_i = o;
        rst_i = 1'b1;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : do_reset
    task rw(input bit cfg, input logic [7:0] d);
        @(negedge clk_i);
        ratio_wdata_i = d;
        config_wdata_i = d;
        ratio_wr_i = !cfg;
        config_wr_i = cfg;
        @(negedge clk_i);
        {ratio_wr_i, config_wr_i} = 2'b00;
        ratio_wdata_i = ~d;
        config_wdata_i = ~d;
        @(negedge clk_i);
    endtask : rw
    // ****************
    // Scenarios
    // ****************
    task t_codes;
        for (int c = 0; c < 4; c++) begin
            do_reset(8'h80 | 8'(c));
            chk("option", 8'h80 | 8'(c), working_option_reg_o);
            chk("secure", 8'(c != 2), 8'(secure_o));
            chk("protect", 8'hF8, working_protect_reg_o);
            chk("ratio", 8'h00, flash_clock_ratio_reg_o);
        end
    endtask : t_codes
    task key_seq(input int cnt, input int bad, input logic dbg, input logic exp_sec);
        rw(1'b1, 8'h20);
        chk("config", 8'h20, flash_config_reg_o);
        for (int i = 0; i < cnt; i++) begin
            i_cpu.acc(1'b1, !dbg, dbg, 1'b1, 16'hFFB0 + 16'(i), KEY[8*i+:8] ^ 8'(i == bad), e, rd, er);
            chk("key write enable", 8'h00, 8'(e));
        end
        rw(1'b1, 8'h00);
        repeat (4) @(negedge clk_i);
        chk("secure after key", 8'(exp_sec), 8'(secure_o));
    endtask : key_seq
    task t_blocked;
        i_cpu.acc(1'b0, 1'b0, 1'b1, 1'b1, 16'h1234, 8'h00, e, rd, er);
        chk("debug read", 8'h00, rd);
        chk("debug enable", 8'h00, 8'(e));
        i_cpu.acc(1'b0, 1'b1, 1'b0, 1'b1, 16'h1234, 8'h00, e, rd, er);
        chk("secure read", 8'h91, rd);
        i_cpu.acc(1'b0, 1'b0, 1'b1, 1'b0, 16'h0040, 8'h00, e, rd, er);
        chk("register read enable", 8'h01, 8'(e));
        chk("debug module", 8'h00, 8'(debug_module_allow_o));
    endtask : t_blocked
    task t_ratio;
        i_cpu.acc(1'b1, 1'b1, 1'b0, 1'b0, 16'h8000, 8'h55, e, rd, er);
        chk("early error", 8'h01, 8'(er));
        chk("early command write", 8'h00, 8'(cmd_seen));
        chk("prog enable", 8'h00, 8'(prog_erase_en_o));
        i_cpu.prot(1'b0, 8'hFF);
        chk("app protect", 8'hF8, working_protect_reg_o);
        i_cpu.prot(1'b1, 8'hFE);
        chk("debug protect", 8'hFE, working_protect_reg_o);
        // Divide by eight then by 25 gives 200 kHz from the 40 MHz bus
        rw(1'b0, 8'h58);
        chk("ratio", 8'hD8, flash_clock_ratio_reg_o);
        chk("prog enable", 8'h01, 8'(prog_erase_en_o));
        rw(1'b0, 8'h07);
        chk("ratio rewrite", 8'hD8, flash_clock_ratio_reg_o);
        i_cpu.acc(1'b1, 1'b1, 1'b0, 1'b0, 16'h8000, 8'h55, e, rd, er);
        chk("late error", 8'h00, 8'(er));
        chk("late command write", 8'h01, 8'(cmd_seen));
        pulse_req_i = 1'b1;
        for (n = 0; n < 400 && pulse_o !== 1'b1; n++) @(negedge clk_i);
        guard(400);
        pulse_req_i = 1'b0;
        for (n = 0; n < 300 && pulse_o === 1'b1; n++) @(negedge clk_i);
        guard(300);
        chk("pulse width", 8'hC8, 8'(n));
    endtask : t_ratio
    task t_blank;
        @(negedge clk_i);
        blank_ok_i = 1'b1;
        @(negedge clk_i);
        blank_ok_i = 1'b0;
        @(negedge clk_i);
        chk("blank unlock", 8'h00, 8'(secure_o));
        i_cpu.acc(1'b0, 1'b0, 1'b1, 1'b1, 16'h1234, 8'h00, e, rd, er);
        chk("open debug read", 8'h91, rd);
    endtask : t_blank
    initial begin
        t_codes();
        key_seq(7, -1, 1'b0, 1'b1);
        key_seq(8, 3, 1'b0, 1'b1);
        key_seq(8, -1, 1'b1, 1'b1);
        key_seq(8, -1, 1'b0, 1'b0);
        chk("unlocked code", 8'h82, working_option_reg_o);
        do_reset(8'h03);
        t_blocked();
        t_ratio();
        key_seq(8, -1, 1'b0, 1'b1);
        t_blank();
        summarize();
    end
endmodule : test_flash_security_and_clock_divider
